// file: design/tx_nrzi_mlt3_line_encoder.sv
// transmit line encoder: 4b/5b mapping, delimiters, scrambling,
// serialisation, nrzi and three-level mlt3 level output
// assumes the mac side presents one nibble per request on the same clock,
// and the line driver takes one level per enabled symbol slot
//
// Notes on behaviour
// - in 100 Mbit copper mode the nrzi stream is turned into mlt3 levels for the driver.
// - each one bit toggles the nrzi level.
// - each zero bit leaves the nrzi level alone.
// - mlt3 uses exactly three levels, low, middle and high, as a two-bit code.
// - each nrzi transition moves mlt3 one step, direction from its state; else it holds.
// - from low, transitions go to middle and then to high.
// - from high, the next transition goes down to middle.
// - from middle on the way down the next transition goes low, and the cycle repeats.
// - code groups are scrambled before nrzi and mlt3 coding.
// - each data nibble maps to a fixed five-bit code group.
// - frames start with 11000 then 10001, and 11111 is sent as idle.
// - frames end with 01101 then 00111, and 00100 marks a transmit error.
`timescale 1ns/1ps
module tx_nrzi_mlt3_line_encoder
  import line_enc_pkg::*;
#(
  parameter bit SCRAMBLE = 1'b1
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_tx_en,
  input  wire logic       i_tx_er,
  input  wire logic [3:0] i_txd,
  input  wire logic       i_nib_valid,
  output logic            o_nib_ready,
  input  wire logic       i_sym_en,
  output logic            o_line_en,
  output logic [1:0]      o_mlt3_lvl,
  output logic            o_nrzi
);

  // ==========================================================================
  // frame framing state
  typedef enum logic [2:0] {
    ST_IDLE, ST_SSD2, ST_DATA, ST_ESD2
  } frm_t;

  frm_t       frm_q;
  frm_t       frm_d;
  logic [4:0] cg_d;
  logic       cg_v;
  logic       take;
  wire        buf_rdy;

  // nibble mapping, start and idle, end and error
  always_comb begin
    frm_d = frm_q;
    cg_d  = CG_IDLE;
    take  = 1'b0;
    cg_v  = 1'b1;
    unique case (frm_q)
      ST_IDLE: begin
        if (i_nib_valid && i_tx_en) begin
          cg_d  = CG_SSD1;
          frm_d = ST_SSD2;
        end
      end
      ST_SSD2: begin
        cg_d  = CG_SSD2;
        frm_d = ST_DATA;
      end
      ST_DATA: begin
        if (!i_nib_valid) begin
          cg_v = 1'b0;
        end else if (i_tx_en) begin
          take = 1'b1;
          cg_d = i_tx_er ? CG_TXERR : enc4b5b(i_txd);
        end else begin
          cg_d  = CG_ESD1;
          frm_d = ST_ESD2;
        end
      end
      ST_ESD2: begin
        cg_d  = CG_ESD2;
        frm_d = ST_IDLE;
      end
    endcase
  end

  wire adv      = cg_v && buf_rdy;
  wire nib_acc  = take && adv && o_nib_ready;
  wire buf_in_v = cg_v && (take ? nib_acc : 1'b1);
  wire buf_push = buf_in_v && buf_rdy;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) frm_q <= ST_IDLE;
    else if (adv) frm_q <= frm_d;
  end

  // nibbles outside a frame are consumed silently; ready is registered, so inside a
  // frame it only rises when nothing went in this cycle and room is sure at the next edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_nib_ready <= 1'b0;
    else o_nib_ready <= buf_rdy && (!i_tx_en || (frm_q == ST_DATA && !buf_push));
  end

  // ==========================================================================
  // two-entry buffer between framing and serialiser
  wire       buf_v;
  wire [4:0] buf_cg;
  logic      ser_rdy;

  skid_buf2 #(.WIDTH(GROUP_W)) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (buf_in_v),
    .o_ready (buf_rdy),
    .i_data  (cg_d),
    .o_valid (buf_v),
    .i_ready (ser_rdy),
    .o_data  (buf_cg)
  );

  // ==========================================================================
  // serialiser, msb first, one bit per symbol enable
  logic [4:0] sh_q;
  logic [2:0] bcnt_q;
  wire        load = i_sym_en && (bcnt_q == 3'h0);
  assign ser_rdy = load;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q   <= CG_IDLE;
      bcnt_q <= 3'h0;
    end else if (load) begin
      sh_q   <= buf_v ? buf_cg : CG_IDLE;
      bcnt_q <= 3'h4;
    end else if (i_sym_en) begin
      sh_q   <= {sh_q[3:0], 1'b0};
      bcnt_q <= bcnt_q - 3'h1;
    end
  end

  wire [4:0] cur_cg = load ? (buf_v ? buf_cg : CG_IDLE) : {sh_q[3:0], 1'b0};
  wire       raw_bit = cur_cg[4];

  // ==========================================================================
  // scramble before line coding
  logic [10:0] lfsr_q;
  wire         lfsr_fb = lfsr_q[10] ^ lfsr_q[8];
  wire         scr_bit = SCRAMBLE ? (raw_bit ^ lfsr_fb) : raw_bit;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) lfsr_q <= SCR_SEED;
    else if (i_sym_en) lfsr_q <= {lfsr_q[9:0], lfsr_fb};
  end

  // ==========================================================================
  // nrzi and mlt3
  logic      nrzi_q;
  logic      dir_q;
  mlt3_lvl_t lvl_q;
  mlt3_lvl_t lvl_d;
  logic      dir_d;
  logic      line_en_q;
  wire       step = i_sym_en && scr_bit;

  // one step per transition, up from low, reverse at top, to low
  always_comb begin
    lvl_d = lvl_q;
    dir_d = dir_q;
    if (step) begin
      unique case (lvl_q)
        LVL_LOW: begin
          lvl_d = LVL_MID;
          dir_d = DIR_UP;
        end
        LVL_MID: lvl_d = dir_q ? LVL_HIGH : LVL_LOW;
        LVL_HIGH: begin
          lvl_d = LVL_MID;
          dir_d = ~DIR_UP;
        end
        default: lvl_d = LVL_MID;
      endcase
    end
  end

  // reset levels; toggle on one, hold on zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nrzi_q    <= NRZI_RST;
      lvl_q     <= LVL_MID;
      dir_q     <= DIR_UP;
      line_en_q <= 1'b0;
    end else begin
      nrzi_q    <= nrzi_q ^ step;
      lvl_q     <= lvl_d;
      dir_q     <= dir_d;
      line_en_q <= i_sym_en;
    end
  end

  assign o_mlt3_lvl = lvl_q;
  assign o_nrzi     = nrzi_q;
  assign o_line_en  = line_en_q;

  // ==========================================================================
  // checks
  property p_nrzi_one;
    @(posedge i_clk) disable iff (!i_rst_n) step |=> (o_nrzi != $past(o_nrzi));
  endproperty
  a_nrzi_one: assert property (p_nrzi_one) else $error("nrzi did not toggle");

  property p_nrzi_zero;
    @(posedge i_clk) disable iff (!i_rst_n) !step |=> $stable(o_nrzi);
  endproperty
  a_nrzi_zero: assert property (p_nrzi_zero) else $error("nrzi changed on zero");

  property p_three;
    @(posedge i_clk) disable iff (!i_rst_n) o_mlt3_lvl != 2'h3;
  endproperty
  a_three: assert property (p_three) else $error("illegal mlt3 code");

  property p_track;
    @(posedge i_clk) disable iff (!i_rst_n) (o_nrzi != $past(o_nrzi)) == !$stable(o_mlt3_lvl);
  endproperty
  a_track: assert property (p_track) else $error("mlt3 not tied to nrzi");

  // helper: level held before the latest change, so climbing and falling middles differ;
  // reset counts as coming from low, since the encoder starts at middle heading up
  mlt3_lvl_t from_lvl_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) from_lvl_q <= LVL_LOW;
    else if (lvl_d != lvl_q) from_lvl_q <= lvl_q;
  end

  property p_rise;
    @(posedge i_clk) disable iff (!i_rst_n) (o_mlt3_lvl == LVL_LOW && step) |=> o_mlt3_lvl == LVL_MID;
  endproperty
  a_rise: assert property (p_rise) else $error("no step up from low");

  // middle on the way up goes high
  property p_up;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_mlt3_lvl == LVL_MID && from_lvl_q == LVL_LOW && step) |=> o_mlt3_lvl == LVL_HIGH;
  endproperty
  a_up: assert property (p_up) else $error("no climb from low");

  property p_top;
    @(posedge i_clk) disable iff (!i_rst_n) (o_mlt3_lvl == LVL_HIGH && step) |=> o_mlt3_lvl == LVL_MID;
  endproperty
  a_top: assert property (p_top) else $error("no fall from high");

  // middle on the way down goes low
  property p_down;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_mlt3_lvl == LVL_MID && from_lvl_q == LVL_HIGH && step) |=> o_mlt3_lvl == LVL_LOW;
  endproperty
  a_down: assert property (p_down) else $error("no fall to low");

  property p_start;
    @(posedge i_clk) disable iff (!i_rst_n)
      (frm_q == ST_IDLE && frm_d == ST_SSD2 && adv) |=> frm_q == ST_SSD2;
  endproperty
  a_start: assert property (p_start) else $error("start pair broken");

  c_tx: cover property (@(posedge i_clk) disable iff (!i_rst_n) frm_q == ST_DATA);
  c_end: cover property (@(posedge i_clk) disable iff (!i_rst_n) frm_q == ST_ESD2);
  c_hi: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_mlt3_lvl == LVL_HIGH);

endmodule : tx_nrzi_mlt3_line_encoder

// file: design/line_enc_pkg.sv
// package for the transmit line encoder: code groups, levels, widths
// assumes one symbol clock; all users import the whole package
package line_enc_pkg;

  // ==========================================================================
  // code group widths
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned GROUP_W  = 5;

  // ==========================================================================
  // control code groups
  localparam logic [4:0] CG_IDLE   = 5'h1F;
  localparam logic [4:0] CG_SSD1   = 5'h18;
  localparam logic [4:0] CG_SSD2   = 5'h11;
  localparam logic [4:0] CG_ESD1   = 5'h0D;
  localparam logic [4:0] CG_ESD2   = 5'h07;
  localparam logic [4:0] CG_TXERR  = 5'h04;

  // ==========================================================================
  // scrambler
  localparam int unsigned  SCR_W     = 11;
  localparam logic [10:0]  SCR_SEED  = 11'h7FF;

  // ==========================================================================
  // reset values
  localparam logic        NRZI_RST  = 1'b0;
  localparam logic        DIR_UP    = 1'b1;

  // two-bit level code given to the analogue driver
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_MID  = 2'b01,
    LVL_HIGH = 2'b10
  } mlt3_lvl_t;

  // ==========================================================================
  // nibble to code group
  function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
    logic [4:0] cg;
    cg = 5'h1E;
    unique case (nib)
      4'h0: cg = 5'h1E;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0A;
      4'h5: cg = 5'h0B;
      4'h6: cg = 5'h0E;
      4'h7: cg = 5'h0F;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'hA: cg = 5'h16;
      4'hB: cg = 5'h17;
      4'hC: cg = 5'h1A;
      4'hD: cg = 5'h1B;
      4'hE: cg = 5'h1C;
      4'hF: cg = 5'h1D;
    endcase
    return cg;
  endfunction : enc4b5b

endpackage : line_enc_pkg

// file: design/skid_buf2.sv
// two-entry valid/ready buffer
// assumes same clock on both sides
`timescale 1ns/1ps
module skid_buf2
  import line_enc_pkg::*;
#(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);

  if (WIDTH < 1) begin : g_bad_width
    $error("skid_buf2: WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem_q [2];
  logic             rd_q;
  logic             wr_q;
  logic [1:0]       cnt_q;
  wire              push = i_valid && (cnt_q != 2'h2);
  wire              pop  = (cnt_q != 2'h0) && i_ready;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rd_q];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 2'h0;
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem_q[wr_q] <= i_data;
  end

endmodule : skid_buf2

// file: dv/line_sink.sv
// far-side model: line driver that paces symbol slots and collects line bits
// assumes the encoder is on the same clock and marks each slot with o_line_en
`timescale 1ns/1ps
module line_sink (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_gap,
  input  wire logic       i_line_en,
  input  wire logic       i_nrzi,
  output logic            o_sym_en
);
  logic [1:0] cnt_q;
  logic       prev_q;
  bit         bits[$];

  initial begin
    o_sym_en = 1'b0;
    cnt_q    = 2'h0;
  end

  // ==========================================================================
  // slot pacing: a gap above zero stalls the encoder's output side
  always @(posedge i_clk) begin
    #1;
    cnt_q    = (cnt_q >= i_gap) ? 2'h0 : cnt_q + 2'h1;
    o_sym_en = i_rst_n && (cnt_q == 2'h0);
  end

  // ==========================================================================
  // a line bit is one where the nrzi level changed against the slot before
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
    end else if (i_line_en === 1'b1) begin
      bits.push_back(i_nrzi ^ prev_q);
      prev_q <= i_nrzi;
    end
  end
endmodule : line_sink

// file: dv/tb.sv
// self-checking bench for the transmit line encoder, scrambler turned off, with a scrambled twin checked against it
// assumes the line sink model paces slots and records the decoded bits
`timescale 1ns/1ps
module tb;
  import line_enc_pkg::*;
  logic       clk, rst_n, tx_en, tx_er, nib_valid, nib_ready;
  logic       sym_en, line_en, nrzi, nrzi_p, dir_e;
  logic [3:0] txd;
  logic [1:0] mlt3, gap;
  mlt3_lvl_t  lvl_e;
  logic       nrzi_s, line_en_s, nrzi_sp, nrzi_pp;
  logic [10:0] lfsr_e;
  int         fail_count, cmp_count;
  logic [4:0] code_tab[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                               5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  tx_nrzi_mlt3_line_encoder #(.SCRAMBLE(1'b0)) tx_nrzi_mlt3_line_encoder_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_tx_en(tx_en), .i_tx_er(tx_er), .i_txd(txd),
    .i_nib_valid(nib_valid), .o_nib_ready(nib_ready), .i_sym_en(sym_en),
    .o_line_en(line_en), .o_mlt3_lvl(mlt3), .o_nrzi(nrzi));
  line_sink line_sink_inst (.i_clk(clk), .i_rst_n(rst_n), .i_gap(gap),
    .i_line_en(line_en), .i_nrzi(nrzi), .o_sym_en(sym_en));
  // scrambled twin in lockstep with the plain encoder
  tx_nrzi_mlt3_line_encoder #(.SCRAMBLE(1'b1)) scr_tx_nrzi_mlt3_line_encoder_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_tx_en(tx_en), .i_tx_er(tx_er), .i_txd(txd),
    .i_nib_valid(nib_valid), .o_nib_ready(), .i_sym_en(sym_en),
    .o_line_en(line_en_s), .o_mlt3_lvl(), .o_nrzi(nrzi_s));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check_value(input string name, input logic [4:0] seen, input logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check_value

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // level model stepped on every slot; any three-level slip shows here
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_e  = LVL_MID;
      dir_e  = 1'b1;
      nrzi_p = 1'b0;
    end else if (line_en === 1'b1) begin
      if (nrzi !== nrzi_p) begin
        if (lvl_e == LVL_MID) begin
          lvl_e = dir_e ? LVL_HIGH : LVL_LOW;
        end else begin
          dir_e = (lvl_e == LVL_LOW);
          lvl_e = LVL_MID;
        end
      end
      nrzi_p = nrzi;
      check_value("mlt3_lvl", 5'(mlt3), 5'(lvl_e));
    end
  end

  // undoing an x11+x9+1 scrambler seeded from the package must give the plain bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_e  = SCR_SEED;
      nrzi_sp = 1'b0;
      nrzi_pp = 1'b0;
    end else if (line_en_s === 1'b1) begin
      check_value("descrambled_bit", 5'(nrzi_s ^ nrzi_sp ^ lfsr_e[10] ^ lfsr_e[8]),
                  5'(nrzi ^ nrzi_pp));
      lfsr_e  = {lfsr_e[9:0], lfsr_e[10] ^ lfsr_e[8]};
      nrzi_sp = nrzi_s;
      nrzi_pp = nrzi;
    end
  end

  // strict waits count a timeout; the end-of-frame wait does not
  task automatic wait_ready(input bit strict);
    int w;
    w = 0;
    @(posedge clk);
    while (nib_ready !== 1'b1 && w < 200) begin
      @(posedge clk);
      w++;
    end
    #1;
    if (strict && w >= 200) check_value("nib_ready_timeout", 5'h0, 5'h1);
  endtask : wait_ready

  // sends nibbles 0..n-1, er marks nibbles sent with tx_er, then decodes the line
  task automatic send_frame(input logic [1:0] g, input int n, input logic [15:0] er);
    logic [4:0] exp[$];
    logic [4:0] got;
    int         s, w;
    gap = g;
    line_sink_inst.bits.delete();
    exp = '{5'h18, 5'h11};
    // raise tx_en one cycle ahead so the registered ready forgets the idle state
    tx_en = 1'b1;
    @(posedge clk);
    #1;
    nib_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      txd   = 4'(i);
      tx_er = er[i];
      exp.push_back(er[i] ? 5'h04 : code_tab[i]);
      wait_ready(1'b1);
    end
    tx_en = 1'b0;
    tx_er = 1'b0;
    wait_ready(1'b0);
    nib_valid = 1'b0;
    exp.push_back(5'h0D);
    exp.push_back(5'h07);
    exp.push_back(5'h1F);
    w = 0;
    while (line_sink_inst.bits.size() < 5 * (exp.size() + 6) && w < 3000) begin
      @(posedge clk);
      w++;
    end
    s = 0;
    while (s < line_sink_inst.bits.size() && line_sink_inst.bits[s]) s++;
    s = s - 2;
    foreach (exp[k]) begin
      for (int b = 0; b < 5; b++) got[4-b] = line_sink_inst.bits[s+5*k+b];
      check_value("code_group", got, exp[k]);
    end
  endtask : send_frame

  // reset in mid-frame returns every output to its start value
  task automatic test_reset_midrun;
    tx_en = 1'b1;
    nib_valid = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b0;
    #1;
    check_value("mlt3_rst", 5'(mlt3), 5'h01);
    check_value("nrzi_rst", 5'(nrzi), 5'h00);
    check_value("ready_rst", 5'(nib_ready), 5'h00);
    check_value("line_en_rst", 5'(line_en), 5'h00);
    tx_en = 1'b0;
    nib_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : test_reset_midrun

  initial begin
    #(40 * 30000);
    fail_count++;
    complete_run();
  end

  initial begin
    {tx_en, tx_er, nib_valid, txd, gap} = '0;
    fail_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    send_frame(2'h0, 16, 16'h0000);
    send_frame(2'h2, 5, 16'h0004);
    test_reset_midrun();
    send_frame(2'h1, 3, 16'h0001);
    complete_run();
  end
endmodule : tb
